// ===== inc/pct_params.svh
// Constants for the packet channel transaction sequencer.
// Function
// - An Okay read reply sends read data the read latency after request end.
// - Read latency is counted in clocks from the read latency field.
// - Request to write data spacing is identical on primary or secondary channel.
// - Okay write ends at later of ack window end and data end.
// - Nack write needs no data; ends at later of window end and data stop.
// - A serial control packet ends the transfer before count value plus one octbytes.
`ifndef PCT_PARAMS_SVH
`define PCT_PARAMS_SVH
`define PCT_OFS_DELAY      8'h00
`define PCT_OFS_LEAD       8'h04
`define PCT_OFS_STATUS     8'h08
`define PCT_RST_ACK_LAT    8'h03
`define PCT_RST_ACKWIN_LAT 8'h05
`define PCT_RST_READ_LAT   8'h07
`define PCT_RST_WRITE_LAT  8'h01
`define PCT_RST_RD_LEAD    8'h04
`define PCT_RST_WR_LEAD    8'h04
`define PCT_LAST_BEAT      2'h3
`define PCT_HTRANS_NSEQ    2'h2
`endif

// ===== inc/pct_pkg.sv
// Types shared by the packet channel transaction sequencer.
package pct_pkg;
  typedef enum logic [1:0] {
    PCT_ACK_NONE = 2'h0,
    PCT_ACK_OKAY = 2'h1,
    PCT_ACK_NACK = 2'h2,
    PCT_ACK_NEXIST = 2'h3
  } pct_ack_e;
  typedef enum logic [1:0] {
    PCT_IDLE = 2'h0,
    PCT_WAIT = 2'h1,
    PCT_DATA = 2'h3,
    PCT_TAIL = 2'h2
  } pct_state_e;
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       reg_space;
    logic [4:0] transfer_count_value;
    logic [7:0] addr;
  } pct_req_s;
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
  } pct_scatter_addr_sub_s;
  typedef struct packed {
    logic [7:0] ack_latency;
    logic [7:0] ack_window_latency;
    logic [7:0] read_latency_field;
    logic [7:0] write_latency_field;
    logic [7:0] scatter_read_lead;
    logic [7:0] scatter_write_lead;
  } pct_cfg_s;
  typedef struct packed {
    pct_state_e state;
    logic       busy;
    logic [4:0] moved;
  } pct_stat_s;
endpackage

// ===== logic/pct_regs.sv
// AHB-Lite register slave holding delay and lead settings and status.
`timescale 1ns/1ps
`default_nettype none
`include "pct_params.svh"
module pct_regs
  import pct_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire pct_stat_s   stat_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output pct_cfg_s         cfg_o
);
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] next_rdata;
  wire        take = hsel_i & hready_i & (htrans_i == `PCT_HTRANS_NSEQ);
  wire  [7:0] a    = haddr_i[7:0];
  wire        unused_ok = &{1'b0, hsize_i, haddr_i[31:8]};

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (a == `PCT_OFS_DELAY) begin
      next_rdata = {cfg_o.write_latency_field, cfg_o.read_latency_field,
                    cfg_o.ack_window_latency, cfg_o.ack_latency};
    end else if (a == `PCT_OFS_LEAD) begin
      next_rdata = {16'h0000, cfg_o.scatter_write_lead,
                    cfg_o.scatter_read_lead};
    end else if (a == `PCT_OFS_STATUS) begin
      next_rdata = {24'h0000_00, stat_i.moved, stat_i.busy, stat_i.state};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_pend  <= 1'b0;
      wr_addr  <= 8'h00;
      hrdata_o <= 32'h0000_0000;
    end else begin
      wr_pend <= take & hwrite_i;
      wr_addr <= a;
      if (take && !hwrite_i) begin
        hrdata_o <= next_rdata;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_o.ack_latency         <= `PCT_RST_ACK_LAT;
      cfg_o.ack_window_latency  <= `PCT_RST_ACKWIN_LAT;
      cfg_o.read_latency_field  <= `PCT_RST_READ_LAT;
      cfg_o.write_latency_field <= `PCT_RST_WRITE_LAT;
      cfg_o.scatter_read_lead   <= `PCT_RST_RD_LEAD;
      cfg_o.scatter_write_lead  <= `PCT_RST_WR_LEAD;
    end else if (wr_pend && wr_addr == `PCT_OFS_DELAY) begin
      {cfg_o.write_latency_field, cfg_o.read_latency_field,
       cfg_o.ack_window_latency, cfg_o.ack_latency} <= hwdata_i;
    end else if (wr_pend && wr_addr == `PCT_OFS_LEAD) begin
      {cfg_o.scatter_write_lead, cfg_o.scatter_read_lead} <= hwdata_i[15:0];
    end
  end
endmodule
`default_nettype wire

// ===== logic/pct_ctrl.sv
// Responder transaction sequencer for the packet memory channel.
`timescale 1ns/1ps
`default_nettype none
`include "pct_params.svh"
module pct_ctrl
  import pct_pkg::*;
#(
  parameter int DW = 8
) (
  input  wire logic          REF_CLK_I,
  input  wire logic          ARST_N_I,
  input  wire logic          HSEL_I,
  input  wire logic [31:0]   HADDR_I,
  input  wire logic [1:0]    HTRANS_I,
  input  wire logic          HWRITE_I,
  input  wire logic [2:0]    HSIZE_I,
  input  wire logic [31:0]   HWDATA_I,
  input  wire logic          HREADY_I,
  output logic [31:0]        HRDATA_O,
  output logic               HREADYOUT_O,
  output logic               HRESP_O,
  input  wire pct_req_s      REQ_I,
  input  wire pct_ack_e      ACK_KIND_I,
  input  wire pct_scatter_addr_sub_s     SCATTER_ADDR_SUB_I,
  input  wire logic          SCTL_I,
  input  wire logic          SECONDARY_I,
  input  wire logic          WR_VALID_I,
  input  wire logic [DW-1:0] WR_DATA_I,
  input  wire logic [DW-1:0] CORE_RDATA_I,
  output pct_ack_e           ACK_O,
  output logic               RD_VALID_O,
  output logic [DW-1:0]      RD_DATA_O,
  output logic [7:0]         OCT_ADDR_O,
  output logic               WR_VALID_O,
  output logic [DW-1:0]      WR_DATA_O,
  output logic               BUSY_O,
  output logic               DONE_O
);
  pct_cfg_s   cfg;
  pct_stat_s  stat;
  pct_state_e state;
  pct_state_e next_state;
  logic [7:0] t;
  logic       is_write;
  logic [4:0] count;
  logic [4:0] oct;
  logic [1:0] beat;
  pct_ack_e   kind;
  logic       win_done;
  logic       stop_arm;
  logic [7:0] stop_cnt;

  pct_regs u_regs (
    .clk_i       (REF_CLK_I),
    .arst_n_i    (ARST_N_I),
    .hsel_i      (HSEL_I),
    .haddr_i     (HADDR_I),
    .htrans_i    (HTRANS_I),
    .hwrite_i    (HWRITE_I),
    .hsize_i     (HSIZE_I),
    .hwdata_i    (HWDATA_I),
    .hready_i    (HREADY_I),
    .stat_i      (stat),
    .hrdata_o    (HRDATA_O),
    .hreadyout_o (HREADYOUT_O),
    .hresp_o     (HRESP_O),
    .cfg_o       (cfg)
  );

  // The data latency does not depend on which channel segment we sit on.
  wire [7:0] data_lat = is_write ? cfg.write_latency_field
                                 : cfg.read_latency_field;
  wire [7:0] lead     = is_write ? cfg.scatter_write_lead
                                 : cfg.scatter_read_lead;
  wire       okay     = (kind == PCT_ACK_OKAY);
  // Ack and read data count from the same request end, so both are timed on t, each at its own latency.
  wire       ack_now  = (state != PCT_IDLE)
                        && (t + 8'h01 == cfg.ack_latency);
  wire       win_end  = win_done || (t >= cfg.ack_window_latency);
  wire       start_dt = (state == PCT_WAIT) && okay
                        && (t + 8'h01 == data_lat);
  wire       last_full = (beat == `PCT_LAST_BEAT)
                        && (oct == count);
  // The last octbyte cycle is lead minus one cycles after the control start.
  wire       last_cut  = stop_arm ? (stop_cnt == 8'h02)
                                  : (SCTL_I && lead == 8'h01);
  wire       data_end  = (state == PCT_DATA) && (last_full || last_cut);
  wire       nack_tail = !okay && !WR_VALID_I;
  wire       finish    = (state == PCT_TAIL) && win_end
                         && (okay || !is_write || nack_tail);
  wire       unused_ok = &{1'b0, SECONDARY_I};

  always_comb begin
    next_state = state;
    unique case (state)
      PCT_IDLE: if (REQ_I.valid) next_state = PCT_WAIT;
      PCT_WAIT: begin
        if (start_dt) next_state = PCT_DATA;
        else if (!okay && t >= cfg.ack_latency) next_state = PCT_TAIL;
      end
      PCT_DATA: if (data_end) next_state = PCT_TAIL;
      PCT_TAIL: if (finish) next_state = PCT_IDLE;
    endcase
  end

  // The request valid pulse marks the last cycle of the request packet.
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state    <= PCT_IDLE;
      t        <= 8'h00;
      is_write <= 1'b0;
      count    <= 5'h00;
      kind     <= PCT_ACK_NONE;
      win_done <= 1'b0;
    end else begin
      state    <= next_state;
      t        <= (state == PCT_IDLE) ? 8'h01 : t + 8'h01;
      win_done <= (state == PCT_IDLE) ? 1'b0 : win_end;
      if (state == PCT_IDLE && REQ_I.valid) begin
        is_write <= REQ_I.write;
        count    <= REQ_I.transfer_count_value;
        kind     <= ACK_KIND_I;
      end
    end
  end

  // Octbyte framing: four channel cycles per octbyte.
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      beat     <= 2'h0;
      oct      <= 5'h00;
      stop_arm <= 1'b0;
      stop_cnt <= 8'h00;
    end else if (state != PCT_DATA) begin
      beat     <= 2'h0;
      oct      <= 5'h00;
      stop_arm <= 1'b0;
    end else begin
      beat <= beat + 2'h1;
      if (beat == `PCT_LAST_BEAT) oct <= oct + 5'h01;
      if (SCTL_I && !stop_arm) begin
        stop_arm <= 1'b1;
        stop_cnt <= lead;
      end else if (stop_arm) begin
        stop_cnt <= stop_cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ACK_O      <= PCT_ACK_NONE;
      RD_VALID_O <= 1'b0;
      RD_DATA_O  <= '0;
      WR_VALID_O <= 1'b0;
      WR_DATA_O  <= '0;
      OCT_ADDR_O <= 8'h00;
      DONE_O     <= 1'b0;
    end else begin
      ACK_O      <= ack_now ? kind : PCT_ACK_NONE;
      RD_VALID_O <= (next_state == PCT_DATA) && !is_write;
      RD_DATA_O  <= CORE_RDATA_I;
      WR_VALID_O <= (state == PCT_DATA) && is_write && WR_VALID_I;
      WR_DATA_O  <= WR_DATA_I;
      DONE_O     <= finish;
      if (state == PCT_IDLE && REQ_I.valid) OCT_ADDR_O <= REQ_I.addr;
      else if (SCATTER_ADDR_SUB_I.valid) OCT_ADDR_O <= SCATTER_ADDR_SUB_I.addr;
    end
  end

  assign BUSY_O     = (state != PCT_IDLE);
  assign stat.state = state;
  assign stat.busy  = BUSY_O;
  assign stat.moved = oct;

  a_read_start: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    $rose(RD_VALID_O) |-> t == cfg.read_latency_field)
    else $error("read data did not start at read latency");
  a_read_okay_only: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
    RD_VALID_O |-> kind == PCT_ACK_OKAY && !is_write)
    else $error("read data sent without okay read");
  a_write_spacing: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
    $rose(state == PCT_DATA) && is_write
      |-> t == cfg.write_latency_field)
    else $error("write window opened at wrong spacing");
  a_okay_end: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    DONE_O |-> $past(win_end) && okay |-> $past(state) == PCT_TAIL)
    else $error("okay transaction ended too early");
  a_nack_nodata: assert property (@(posedge REF_CLK_I)
    disable iff (!ARST_N_I)
    !okay && state != PCT_IDLE |-> state != PCT_DATA)
    else $error("data phase entered after nack");
  a_nack_wait: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    state == PCT_TAIL && is_write && !okay && WR_VALID_I
      |=> state == PCT_TAIL)
    else $error("nack write ended while data still driven");
  a_full_count: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    state == PCT_DATA && !stop_arm && oct == count
      && beat == `PCT_LAST_BEAT |=> state == PCT_TAIL)
    else $error("data packet exceeded count plus one octbytes");
  a_early_stop: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
    state == PCT_DATA && SCTL_I && !stop_arm && lead == 8'h02
      |-> ##1 state == PCT_DATA ##1 state == PCT_TAIL)
    else $error("serial control did not end data on time");
endmodule
`default_nettype wire

// ===== dv/pct_init_model.sv
// Initiating controller model: request, write data, scatter and control.
`timescale 1ns/1ps
`default_nettype none
module pct_init_model
  import pct_pkg::*;
#(
  parameter int DW = 8
) (
  input  wire logic     clk_i,
  input  wire logic     rd_valid_i,
  output pct_req_s      req_o,
  output pct_ack_e      ack_kind_o,
  output pct_scatter_addr_sub_s     scatter_addr_sub_o,
  output logic          sctl_o,
  output logic          wr_valid_o,
  output logic [DW-1:0] wr_data_o
);
  pct_req_s   cmd;
  logic       go;
  logic [7:0] cnt;
  logic [7:0] wlat;
  logic [7:0] rd_seen;
  logic [7:0] sctl_n;
  logic [7:0] scatter_addr_sub_t;
  logic [8:0] nt;
  logic [8:0] wend;
  logic       act;
  logic       wv;
  logic [7:0] wlead;
  logic [8:0] stop_at;
  wire        seen = cmd.write ? wr_valid_o : rd_valid_i;
  initial begin
    {cmd, go, cnt, wlat, rd_seen, sctl_n, scatter_addr_sub_t, wlead} = '0;
    stop_at = 9'h1FF;
    {req_o, scatter_addr_sub_o, sctl_o, wr_valid_o, wr_data_o} = '0;
    ack_kind_o = PCT_ACK_NONE;
  end
  assign act  = req_o.valid || cnt != 8'h00;
  assign nt   = req_o.valid ? 9'h001 : 9'(cnt) + 9'h001;
  assign wend = 9'(wlat) + 9'({cmd.transfer_count_value, 2'b00}) + 9'h004;
  // One write latency serves every responder, so all see the same spacing.
  assign wv = cmd.write && act && nt >= 9'(wlat) && nt < wend
              && nt < stop_at;
  task automatic start(input pct_req_s c, input pct_ack_e k,
                       input logic [7:0] wl, input logic [7:0] sn,
                       input logic [7:0] st, input logic [7:0] ld);
    cmd <= c;
    wlead <= ld;
    stop_at <= 9'h1FF;
    ack_kind_o <= k;
    wlat <= wl;
    sctl_n <= sn;
    scatter_addr_sub_t <= st;
    go <= 1'b1;
  endtask
  always @(posedge clk_i) begin
    req_o <= go ? cmd : '0;
    if (go) begin
      go <= 1'b0;
    end
    cnt <= req_o.valid ? 8'h01 : (cnt != 8'h00 ? cnt + 8'h01 : 8'h00);
    // Data stops after its length whatever the acknowledge was.
    wr_valid_o <= wv;
    // A released data line shows the inverse of its last value.
    wr_data_o <= wv ? DW'(nt) : ~wr_data_o;
    rd_seen <= req_o.valid ? 8'h00 : rd_seen + 8'(seen);
    // Control lands in the data phase, well clear of the ack window.
    sctl_o <= sctl_n != 8'h00 && seen
              && rd_seen + 8'h01 == sctl_n;
    // A cut write stops its data one write lead after the control start.
    if (cmd.write && sctl_n != 8'h00 && seen && rd_seen + 8'h01 == sctl_n) begin
      stop_at <= nt + 9'(wlead);
    end
    scatter_addr_sub_o.valid <= act && nt == 9'(scatter_addr_sub_t);
    scatter_addr_sub_o.addr <= cmd.addr + 8'h01;
  end
endmodule
`default_nettype wire

// ===== dv/test_packet_channel_transactions.sv
// Testbench for the packet channel transaction sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "pct_params.svh"
module test_packet_channel_transactions;
  import pct_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic        hready;
  logic        secondary = 1'b0;
  logic [7:0]  core_rdata = '0;
  logic [7:0]  rd_data, oct_addr, wr_data_o, wr_data;
  logic        rd_valid, wr_valid_o, wr_valid, sctl, busy, done;
  pct_req_s    req;
  pct_scatter_addr_sub_s   scatter_addr_sub;
  pct_ack_e    ack, ack_kind;
  int          num_errors = 0;
  int          cmp_count = 0;
  logic [31:0] d;
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) core_rdata <= core_rdata + 8'h01;
  pct_init_model i_init (.clk_i(clk), .rd_valid_i(rd_valid), .req_o(req),
    .ack_kind_o(ack_kind), .scatter_addr_sub_o(scatter_addr_sub), .sctl_o(sctl),
    .wr_valid_o(wr_valid), .wr_data_o(wr_data));
  pct_ctrl i_dut (.REF_CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .REQ_I(req),
    .ACK_KIND_I(ack_kind), .SCATTER_ADDR_SUB_I(scatter_addr_sub), .SCTL_I(sctl),
    .SECONDARY_I(secondary), .WR_VALID_I(wr_valid), .WR_DATA_I(wr_data),
    .CORE_RDATA_I(core_rdata), .ACK_O(ack), .RD_VALID_O(rd_valid),
    .RD_DATA_O(rd_data), .OCT_ADDR_O(oct_addr), .WR_VALID_O(wr_valid_o),
    .WR_DATA_O(wr_data_o), .BUSY_O(busy), .DONE_O(done));
  task automatic end_of_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= `PCT_HTRANS_NSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic txn(input logic w, input logic [4:0] cv, input pct_ack_e k,
                     input logic [7:0] sn, input logic [7:0] st,
                     input int exp_rd, input int exp_wr);
    int i, a_t, r_t, rn, wn;
    pct_ack_e got;
    {a_t, r_t, rn, wn} = '0;
    got = PCT_ACK_NONE;
    @(posedge clk);
    i_init.start('{1'b1, w, 1'b0, cv, 8'h30}, k, 8'h02, sn, st, 8'h04);
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      #1;
      if (ack !== PCT_ACK_NONE && a_t == 0) begin
        a_t = i;
        got = ack;
      end
      if (rd_valid === 1'b1) begin
        r_t = (r_t == 0) ? i : r_t;
        rn++;
        chk(32'(rd_data), 32'(core_rdata - 8'h01));
      end
      wn += (wr_valid_o === 1'b1) ? 1 : 0;
      if (done === 1'b1)
        break;
    end
    if (i == 300) begin
      num_errors++;
      end_of_test();
    end
    chk(32'(got), 32'(k));
    chk(rn, exp_rd);
    if (exp_rd != 0)
      chk(r_t - a_t, 7);
    if (exp_wr >= 0)
      chk(wn, exp_wr);
    // A gap of three cycles is left after every transaction, read or write, before the next request to this device.
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    ahb(1'b0, `PCT_OFS_DELAY, '0, d);
    chk(d, {`PCT_RST_WRITE_LAT, `PCT_RST_READ_LAT, `PCT_RST_ACKWIN_LAT,
            `PCT_RST_ACK_LAT});
    ahb(1'b0, `PCT_OFS_LEAD, '0, d);
    chk(d, {16'h0000, `PCT_RST_WR_LEAD, `PCT_RST_RD_LEAD});
    ahb(1'b1, `PCT_OFS_STATUS, 32'hFFFF_FFFF, d);
    ahb(1'b0, `PCT_OFS_STATUS, '0, d);
    chk(d, 32'h0000_0000);
    ahb(1'b1, 32'h0000_000C, 32'hFFFF_FFFF, d);
    ahb(1'b0, 32'h0000_000C, '0, d);
    chk(d, 32'h0000_0000);
    ahb(1'b1, `PCT_OFS_DELAY, 32'h0209_0402, d);
    ahb(1'b0, `PCT_OFS_DELAY, '0, d);
    chk(d, 32'h0209_0402);
    ahb(1'b1, `PCT_OFS_LEAD, 32'h0000_0402, d);
    ahb(1'b0, `PCT_OFS_LEAD, '0, d);
    chk(d, 32'h0000_0402);
    txn(1'b0, 5'h01, PCT_ACK_OKAY, 8'h00, 8'h09, 8, -1);
    chk(32'(oct_addr), 32'h0000_0031);
    txn(1'b0, 5'h00, PCT_ACK_NACK, 8'h00, 8'h00, 0, -1);
    txn(1'b0, 5'h00, PCT_ACK_NEXIST, 8'h00, 8'h00, 0, -1);
    txn(1'b0, 5'h03, PCT_ACK_OKAY, 8'h01, 8'h00, 3, -1);
    for (int s = 0; s < 2; s++) begin
      secondary <= 1'(s);
      txn(1'b1, 5'h02, PCT_ACK_OKAY, 8'h00, 8'h00, 0, 12);
    end
    txn(1'b1, 5'h01, PCT_ACK_NACK, 8'h00, 8'h00, 0, -1);
    txn(1'b1, 5'h03, PCT_ACK_OKAY, 8'h03, 8'h00, 0, 7);
    end_of_test();
  end
endmodule
`default_nettype wire
